// *** design/vdp_packet_sender.sv ***
`default_nettype none

module vdp_packet_sender (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire vdp_pkg::vdp_pmode_t           portMode,
  input  wire logic                          portEnable,
  input  wire logic                          vsync,
  input  wire logic                          blankActive,
  input  wire logic [vdp_pkg::NUM_TYPES-1:0] packetEnable,
  input  wire logic                          bufWrite,
  input  wire vdp_pkg::vdp_ptype_t           bufType,
  input  wire logic [3:0]                    bufDword,
  input  wire logic [31:0]                   bufWriteData,
  output logic [31:0]                        bufReadData,
  output logic                               txValid,
  input  wire logic                          txReady,
  output logic [31:0]                        txData,
  output logic [3:0]                         txKind,
  output logic                               txFirst,
  output logic                               txLast
);
  import vdp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND} vdp_state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0]          mem_reg  [NUM_TYPES][DATA_DWORDS];
  logic [31:0]          mem_next [NUM_TYPES][DATA_DWORDS];
  logic [31:0]          rd_reg;
  logic [31:0]          rd_next;
  vdp_state_t           state_reg;
  vdp_state_t           state_next;
  logic [NUM_TYPES-1:0] pend_reg;
  logic [NUM_TYPES-1:0] pend_next;
  logic [NUM_TYPES-1:0] enPrev_reg;
  logic                 nullPend_reg;
  logic                 nullPend_next;
  logic                 nullCur_reg;
  logic                 nullCur_next;
  vdp_ptype_t           cur_reg;
  vdp_ptype_t           cur_next;
  logic [3:0]           idx_reg;
  logic [3:0]           idx_next;
  logic                 vsPrev_reg;

  logic                 hdmi;
  logic                 frameStart;
  logic [NUM_TYPES-1:0] allowed;
  logic                 found;
  vdp_ptype_t           pick;
  logic [3:0]           lastIdx;
  logic [31:0]          sendWord;

  vdp_word_if #(.W(WORD_W)) word ();

  // ----------------------------------------
  // Buffer layout helpers
  // ----------------------------------------
  function automatic logic isShort(input vdp_ptype_t t);
    return (t == TY_AVI) || (t == TY_SPD) || (t == TY_VS) ||
           (t == TY_DRM);
  endfunction

  function automatic logic [3:0] lastDword(input vdp_ptype_t t);
    if (isShort(t))
      return DW_LAST_SHORT;
    else if (t == TY_VSC)
      return DW_LAST_VSC;
    else
      return DW_LAST_SHARED;
  endfunction

  // ECC folds bytes by XOR; the sink only needs a value from the octets
  function automatic logic [31:0] readWord(input vdp_ptype_t t,
                                           input logic [3:0] i,
                                           input logic       h);
    logic        threeHdr;
    logic [31:0] hm;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [7:0]  hecc1;
    logic [31:0] hecc4;
    logic [31:0] d;
    logic [31:0] r;
    threeHdr = isShort(t) || (h && t != TY_VSC);
    hm    = threeHdr ? {8'h00, mem_reg[t][0][23:0]} : mem_reg[t][0];
    lo    = mem_reg[t][1] ^ mem_reg[t][3] ^ mem_reg[t][5] ^ mem_reg[t][7];
    hi    = mem_reg[t][2] ^ mem_reg[t][4] ^ mem_reg[t][6] ^
            (isShort(t) ? 32'h0000_0000 : mem_reg[t][8]);
    hecc1 = hm[31:24] ^ hm[23:16] ^ hm[15:8] ^ hm[7:0];
    hecc4 = {hm[31:24] ^ hm[7:0], hm[23:16] ^ hm[7:0],
             hm[15:8] ^ hm[7:0], hecc1};
    d     = (i < DW_LONG_DATA_END) ? mem_reg[t][i] : 32'h0000_0000;
    r     = 32'h0000_0000;
    if (i == 4'h0)
      r = hm;
    else if (isShort(t)) begin
      if (i < DW_SHORT_DATA_END)
        r = d;
      else if (i == DW_SHORT_HECC)
        r = {24'h00_0000, hecc1};
      else if (i == DW_SHORT_PECC)
        r = lo ^ hi;
    end else if (i < DW_LONG_DATA_END)
      r = d;
    else if (t == TY_VSC) begin
      if (i == DW_VSC_HECC)
        r = hecc4;
      else if (i == DW_VSC_PECC0)
        r = lo;
      else if (i == DW_VSC_PECC1)
        r = hi;
    end else if (h) begin
      if (i == DW_SH_HDMI_HECC)
        r = {24'h00_0000, hecc1};
      else if (i == DW_SH_HDMI_PECC)
        r = lo ^ hi;
    end else begin
      if (i == DW_SH_DP_HECC)
        r = hecc4;
      else if (i == DW_SH_DP_PECC0)
        r = lo;
      else if (i == DW_SH_DP_PECC1)
        r = hi;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Buffer writes and readback
  // ----------------------------------------
  always_comb begin
    mem_next = mem_reg;
    if (bufWrite && bufDword <
        (isShort(bufType) ? DW_SHORT_DATA_END : DW_LONG_DATA_END))
      mem_next[bufType][bufDword] = bufWriteData;
    rd_next = readWord(bufType, bufDword, hdmi);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < NUM_TYPES; t++)
        for (int d = 0; d < DATA_DWORDS; d++)
          mem_reg[t][d] <= DWORD_RESET;
      rd_reg <= DWORD_RESET;
    end else begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
    end
  end

  assign bufReadData = rd_reg;

  // ----------------------------------------
  // Frame scheduler
  // ----------------------------------------
  always_comb begin
    hdmi = (portMode == PM_HDMI);
    case (portMode)
      PM_HDMI: allowed = TYPES_HDMI;
      PM_DP:   allowed = TYPES_DP;
      PM_EDP:  allowed = TYPES_EDP;
      default: allowed = '0;
    endcase
    // Inputs come from transcoder timing on this clock, no synchroniser
    frameStart = vsync & ~vsPrev_reg;
    found = 1'b0;
    pick  = TY_GCP;
    for (int t = NUM_TYPES - 1; t >= 0; t--) begin
      if (pend_reg[t]) begin
        found = 1'b1;
        pick  = vdp_ptype_t'(t);
      end
    end
    lastIdx  = nullCur_reg ? DW_LAST_SHORT : lastDword(cur_reg);
    sendWord = nullCur_reg ? 32'h0000_0000 : readWord(cur_reg, idx_reg, hdmi);

    state_next    = state_reg;
    pend_next     = pend_reg;
    nullPend_next = nullPend_reg;
    nullCur_next  = nullCur_reg;
    cur_next      = cur_reg;
    idx_next      = idx_reg;
    word.valid    = 1'b0;
    word.payload  = {nullCur_reg, cur_reg, idx_reg == 4'h0,
                     idx_reg == lastIdx, sendWord};
    case (state_reg)
      ST_IDLE: begin
        if (blankActive && portEnable && found) begin
          state_next      = ST_SEND;
          cur_next        = pick;
          nullCur_next    = 1'b0;
          idx_next        = 4'h0;
          pend_next[pick] = 1'b0;
        end else if (blankActive && portEnable && nullPend_reg) begin
          state_next    = ST_SEND;
          // Null kind is fixed, not left over from the last packet
          cur_next      = TY_GCP;
          nullCur_next  = 1'b1;
          idx_next      = 4'h0;
          nullPend_next = 1'b0;
        end
      end
      ST_SEND: begin
        word.valid = portEnable;
        // Type enables are ignored here; only portEnable low cuts a started packet short
        if (!portEnable)
          state_next = ST_IDLE;
        else if (word.ready) begin
          idx_next = idx_reg + 4'h1;
          if (idx_reg == lastIdx)
            state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Uses last cycle's enables: one set on this edge waits a frame
    if (frameStart) begin
      pend_next     = enPrev_reg & allowed;
      nullPend_next = hdmi && ((enPrev_reg & allowed) == '0);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      pend_reg     <= '0;
      enPrev_reg   <= '0;
      nullPend_reg <= 1'b0;
      nullCur_reg  <= 1'b0;
      cur_reg      <= TY_GCP;
      idx_reg      <= 4'h0;
      vsPrev_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pend_reg     <= pend_next;
      enPrev_reg   <= packetEnable;
      nullPend_reg <= nullPend_next;
      nullCur_reg  <= nullCur_next;
      cur_reg      <= cur_next;
      idx_reg      <= idx_next;
      vsPrev_reg   <= vsync;
    end
  end

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  logic [WORD_W-1:0] outWord;

  vdp_skid_buffer #(.W(WORD_W)) u_buffer (
    .clock    (clock),
    .rst      (rst),
    .fill     (word.snk),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (outWord)
  );

  assign txKind  = outWord[37:34];
  assign txFirst = outWord[33];
  assign txLast  = outWord[32];
  assign txData  = outWord[31:0];

endmodule

`default_nettype wire

// *** design/vdp_pkg.sv ***
`default_nettype none

package vdp_pkg;

  // ----------------------------------------
  // Packet types and port modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    TY_GCP, TY_AVI, TY_SPD, TY_VS, TY_GMP, TY_DRM, TY_VSC, TY_PPS
  } vdp_ptype_t;

  typedef enum logic [1:0] {PM_HDMI, PM_DP, PM_EDP} vdp_pmode_t;

  localparam int          NUM_TYPES   = 8;
  localparam int          DATA_DWORDS = 9;
  localparam logic [7:0]  TYPES_HDMI  = 8'h3F;
  localparam logic [7:0]  TYPES_DP    = 8'hD0;
  localparam logic [7:0]  TYPES_EDP   = 8'h50;

  // ----------------------------------------
  // Buffer layout
  // ----------------------------------------
  localparam logic [3:0]  DW_SHORT_DATA_END = 4'h8;
  localparam logic [3:0]  DW_LONG_DATA_END  = 4'h9;
  localparam logic [3:0]  DW_SHORT_HECC     = 4'h8;
  localparam logic [3:0]  DW_SHORT_PECC     = 4'h9;
  localparam logic [3:0]  DW_SH_HDMI_HECC   = 4'h9;
  localparam logic [3:0]  DW_SH_HDMI_PECC   = 4'hA;
  localparam logic [3:0]  DW_SH_DP_HECC     = 4'hB;
  localparam logic [3:0]  DW_SH_DP_PECC0    = 4'hC;
  localparam logic [3:0]  DW_SH_DP_PECC1    = 4'hD;
  localparam logic [3:0]  DW_VSC_HECC       = 4'h9;
  localparam logic [3:0]  DW_VSC_PECC0      = 4'hA;
  localparam logic [3:0]  DW_VSC_PECC1      = 4'hB;
  localparam logic [3:0]  DW_LAST_SHORT     = 4'h9;
  localparam logic [3:0]  DW_LAST_SHARED    = 4'hD;
  localparam logic [3:0]  DW_LAST_VSC       = 4'hB;
  localparam logic [31:0] DWORD_RESET       = 32'h0000_0000;

  // ----------------------------------------
  // Stream word: {null, type, first, last, data}
  // ----------------------------------------
  localparam int          WORD_W = 38;

endpackage

`default_nettype wire

// *** design/vdp_skid_buffer.sv ***
`default_nettype none

// Two entries; all outputs are flops so a stalled sink loses nothing
module vdp_skid_buffer #(
  parameter int W = 38
) (
  input  wire logic         clock,
  input  wire logic         rst,
  vdp_word_if.snk           fill,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  import vdp_pkg::*;

  logic         outValid_reg;
  logic         outValid_next;
  logic [W-1:0] outData_reg;
  logic [W-1:0] outData_next;
  logic         skValid_reg;
  logic         skValid_next;
  logic [W-1:0] skData_reg;
  logic [W-1:0] skData_next;
  logic         push;
  logic         outFree;

  assign fill.ready = ~skValid_reg;
  assign outValid   = outValid_reg;
  assign outData    = outData_reg;

  always_comb begin
    push          = fill.valid & ~skValid_reg;
    outFree       = ~outValid_reg | outReady;
    outValid_next = outValid_reg;
    outData_next  = outData_reg;
    skValid_next  = skValid_reg;
    skData_next   = skData_reg;
    if (outFree) begin
      if (skValid_reg) begin
        outValid_next = 1'b1;
        outData_next  = skData_reg;
        skValid_next  = 1'b0;
      end else begin
        outValid_next = push;
        outData_next  = push ? fill.payload : outData_reg;
      end
    end else if (push) begin
      // Sink stalled: park the word, ready drops next cycle
      skValid_next = 1'b1;
      skData_next  = fill.payload;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid_reg <= 1'b0;
      outData_reg  <= '0;
      skValid_reg  <= 1'b0;
      skData_reg   <= '0;
    end else begin
      outValid_reg <= outValid_next;
      outData_reg  <= outData_next;
      skValid_reg  <= skValid_next;
      skData_reg   <= skData_next;
    end
  end

endmodule

`default_nettype wire

// *** design/vdp_word_if.sv ***
`default_nettype none

interface vdp_word_if #(parameter int W = 38);
  logic         valid;
  logic         ready;
  logic [W-1:0] payload;

  modport src (output valid, output payload, input ready);
  modport snk (input valid, input payload, output ready);
endinterface

`default_nettype wire

// *** testbench/vdp_packet_sender_properties.sv ***
`default_nettype none
module vdp_packet_sender_properties (
  input wire logic                clock,
  input wire logic                rst,
  input wire vdp_pkg::vdp_pmode_t portMode,
  input wire logic                blankActive,
  input wire vdp_pkg::vdp_ptype_t bufType,
  input wire logic [3:0]          bufDword,
  input wire logic [31:0]         bufReadData,
  input wire logic                txValid,
  input wire logic                txReady,
  input wire logic [31:0]         txData,
  input wire logic [3:0]          txKind,
  input wire logic                txFirst,
  input wire logic                txLast
);
  timeunit 1ns;
  timeprecision 100ps;
  import vdp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [3:0] cnt;
  logic [7:0] allow;
  // ----
  // Words taken in the current packet
  // ----
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else if (txValid && txReady) cnt <= txLast ? 4'h0 : cnt + 4'h1;
  end
  assign allow = portMode == PM_HDMI ? TYPES_HDMI :
                 portMode == PM_DP ? TYPES_DP : TYPES_EDP;
  sequence stalled;
    txValid && !txReady;
  endsequence
  sequence held;
    txValid && $stable(txData) && $stable(txKind) && $stable(txLast);
  endsequence
  a_stall_hold: assert property (stalled |=> held)
    else $error("stalled word changed");
  a_no_cut: assert property (txValid && txReady && !txLast
    |-> ##[1:3] (txValid && !txFirst)) else $error("packet cut");
  a_first_zero: assert property (txValid && txFirst |-> cnt == 4'h0)
    else $error("first word late");
  a_pkt_len: assert property (txValid && txLast |-> cnt ==
    (txKind inside {4'h0, 4'h4, 4'h7} ? 4'hD : txKind == 4'h6 ? 4'hB : 4'h9))
    else $error("bad length");
  a_null_zero: assert property (txValid && txKind[3] |->
    txData == 32'h0 && portMode == PM_HDMI) else $error("bad null word");
  a_type_ok: assert property (txValid && !txKind[3] |->
    allow[txKind[2:0]]) else $error("type not allowed");
  a_blank_start: assert property ($rose(txFirst) |->
    $past(blankActive, 2)) else $error("start outside blanking");
  a_rsv_short: assert property (bufDword > 4'h9 &&
    bufType inside {TY_AVI, TY_SPD, TY_VS, TY_DRM} |=> bufReadData == 32'h0)
    else $error("reserved not zero");
  a_rsv_shared: assert property (
    bufType inside {TY_GCP, TY_GMP, TY_PPS} && (portMode == PM_HDMI ?
    bufDword > 4'hA : bufDword inside {4'h9, 4'hA}) |=> bufReadData == 32'h0)
    else $error("reserved not zero");
endmodule
`default_nettype wire

// *** testbench/vdp_packet_sender_tb_top.sv ***
`default_nettype none
module vdp_packet_sender_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vdp_pkg::*;
  localparam logic [31:0] HDR = 32'hAA07_0301;
  logic        clock;
  logic        rst = 1'b1;
  vdp_pmode_t  portMode = PM_HDMI;
  logic        portEnable = 1'b1;
  logic        vsync = 1'b0;
  logic        blankActive = 1'b0;
  logic [7:0]  packetEnable = 8'h00;
  logic        bufWrite = 1'b0;
  vdp_ptype_t  bufType = TY_GCP;
  logic [3:0]  bufDword = 4'h0;
  logic [31:0] bufWriteData = 32'h0;
  logic        slow = 1'b0;
  logic [31:0] bufReadData;
  logic        txValid;
  logic        txReady;
  logic [31:0] txData;
  logic [3:0]  txKind;
  logic        txFirst;
  logic        txLast;
  int          error_cnt = 0;
  int          checked = 0;
  logic [31:0] exp [14];
  logic [31:0] expCnt [16] = '{default: 32'h0};
  vdp_packet_sender dut (
    .clock(clock), .rst(rst), .portMode(portMode), .portEnable(portEnable),
    .vsync(vsync), .blankActive(blankActive), .packetEnable(packetEnable),
    .bufWrite(bufWrite), .bufType(bufType), .bufDword(bufDword),
    .bufWriteData(bufWriteData), .bufReadData(bufReadData),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .txKind(txKind), .txFirst(txFirst), .txLast(txLast));
  vdp_sink_model sink (
    .clock(clock), .rst(rst), .slow(slow), .txValid(txValid),
    .txData(txData), .txKind(txKind), .txLast(txLast), .txReady(txReady));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ----
  // Helpers
  // ----
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(logic [31:0] e, logic [31:0] a);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  // Strobe left high; caller drops it once after a burst
  task automatic wr(vdp_ptype_t t, int d, logic [31:0] v);
    bufWrite <= 1'b1;
    bufType <= t;
    bufDword <= d[3:0];
    bufWriteData <= v;
    tick(1);
  endtask
  task automatic cnts();
    for (int k = 0; k < 16; k++) chk(expCnt[k], sink.pktCnt[k]);
  endtask
  function automatic logic [31:0] pat(int k);
    return 32'h1357_9BDF ^ (k * 32'h0101_0321);
  endfunction
  task automatic results();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_ecc(vdp_ptype_t t, vdp_pmode_t m, int nd, int h, int p,
                       bit four, int last);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] hd;
    logic [7:0]  x;
    portMode <= m;
    hd = four ? HDR : {8'h00, HDR[23:0]};
    x = hd[31:24] ^ hd[23:16] ^ hd[15:8] ^ hd[7:0];
    lo = 32'h0;
    hi = 32'h0;
    exp[0] = hd;
    // Buffers are rewritten only while every type is disabled
    wr(t, 0, HDR);
    for (int k = 1; k < 14; k++) begin
      exp[k] = (k < nd) ? pat(k) : 32'h0;
      if (k < nd) wr(t, k, pat(k));
      if (k % 2) lo ^= exp[k];
      else hi ^= exp[k];
    end
    // Read-only places are written too; they must not change
    wr(t, h, 32'hFFFF_FFFF);
    wr(t, p, 32'hFFFF_FFFF);
    bufWrite <= 1'b0;
    exp[h] = four ? {hd[31:24] ^ hd[7:0], hd[23:16] ^ hd[7:0],
                     hd[15:8] ^ hd[7:0], x} : {24'h0, x};
    exp[p] = four ? lo : lo ^ hi;
    if (four) exp[p + 1] = hi;
    for (int k = 0; k <= last; k++) begin
      bufType <= t;
      bufDword <= k[3:0];
      tick(2);
      chk(exp[k], bufReadData);
    end
  endtask
  task automatic frame(logic [7:0] en, bit atEdge);
    logic [31:0] w;
    if (!atEdge) packetEnable <= en;
    tick(1);
    vsync <= 1'b1;
    if (atEdge) packetEnable <= en;
    w = sink.wordCnt;
    tick(20);
    chk(w, sink.wordCnt);
    blankActive <= 1'b1;
    tick(300);
    blankActive <= 1'b0;
    vsync <= 1'b0;
    tick(20);
  endtask
  task automatic t_dp();
    portMode <= PM_DP;
    slow <= 1'b1;
    frame(8'hFF, 0);
    frame(8'hFF, 0);
    expCnt[4] += 2;
    expCnt[6] += 3;
    expCnt[7] += 2;
    frame(8'h40, 0);
    cnts();
    for (int k = 0; k < 12; k++) chk(exp[k], sink.words[k]);
  endtask
  task automatic t_hdmi();
    portMode <= PM_HDMI;
    slow <= 1'b0;
    frame(8'h00, 0);
    frame(8'h01, 1);
    expCnt[8] += 2;
    cnts();
    frame(8'h01, 0);
    expCnt[0] += 1;
    cnts();
  endtask
  // Enable dropped while the packet is on the wire
  task automatic t_mid();
    int n;
    slow <= 1'b1;
    packetEnable <= 8'h02;
    tick(1);
    vsync <= 1'b1;
    blankActive <= 1'b1;
    for (n = 0; n < 100 && txValid !== 1'b1; n++) tick(1);
    if (n == 100) begin
      error_cnt++;
      results();
    end
    packetEnable <= 8'h00;
    tick(200);
    blankActive <= 1'b0;
    vsync <= 1'b0;
    expCnt[1] += 1;
    cnts();
  endtask
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(1);
    t_ecc(TY_AVI, PM_HDMI, 8, 8, 9, 0, 13);
    t_ecc(TY_DRM, PM_HDMI, 8, 8, 9, 0, 13);
    t_ecc(TY_GCP, PM_HDMI, 9, 9, 10, 0, 13);
    t_ecc(TY_GCP, PM_DP, 9, 11, 12, 1, 13);
    t_ecc(TY_VSC, PM_DP, 9, 9, 10, 1, 11);
    t_dp();
    t_hdmi();
    t_mid();
    results();
  end
endmodule
bind vdp_packet_sender vdp_packet_sender_properties props (
  .clock(clock), .rst(rst), .portMode(portMode), .blankActive(blankActive),
  .bufType(bufType), .bufDword(bufDword), .bufReadData(bufReadData),
  .txValid(txValid), .txReady(txReady), .txData(txData),
  .txKind(txKind), .txFirst(txFirst), .txLast(txLast));
`default_nettype wire

// *** testbench/vdp_sink_model.sv ***
`default_nettype none
// ----
// Sink
// ----
module vdp_sink_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        txValid,
  input  wire logic [31:0] txData,
  input  wire logic [3:0]  txKind,
  input  wire logic        txLast,
  output logic             txReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] pktCnt [16];
  logic [31:0] words [16];
  logic [31:0] wordCnt;
  logic [3:0]  idx;
  // Half-rate ready when slow, so the buffer must hold words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
      wordCnt <= 32'h0;
      idx <= 4'h0;
      pktCnt <= '{default: 32'h0};
    end else begin
      txReady <= slow ? !txReady : 1'b1;
      if (txValid && txReady) begin
        words[idx] <= txData;
        wordCnt <= wordCnt + 32'h1;
        idx <= txLast ? 4'h0 : idx + 4'h1;
        if (txLast) pktCnt[txKind] <= pktCnt[txKind] + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire
